// ===== rtl/fcm_index_timer.v
`timescale 1ns/1ps
module fcm_index_timer #(
  parameter W = 6
) (
  // clock and reset
  input  wire         sys_clk,
  input  wire         rst_n,
  // control
  input  wire         load,
  input  wire         stop,
  input  wire         tick,
  input  wire [W-1:0] load_value,
  // status
  output reg          running_q,
  output reg          expire_q
);

  reg [W-1:0] cnt_q;

  // stop beats load so a motor command always wins
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= {W{1'b0}};
      running_q <= 1'b0;
      expire_q  <= 1'b0;
    end else begin
      expire_q <= 1'b0;
      if (stop) begin
        running_q <= 1'b0;
      end else if (load) begin
        cnt_q     <= load_value;
        running_q <= (load_value != {W{1'b0}});
      end else if (running_q && tick) begin
        // first edge may come early in a turn: short by up to one rev
        cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        if (cnt_q == {{(W-1){1'b0}}, 1'b1}) begin
          running_q <= 1'b0;
          expire_q  <= 1'b1;
        end
      end
    end
  end

endmodule

// ===== rtl/fcm_regs.vh
`ifndef FCM_REGS_VH
`define FCM_REGS_VH

// first configuration byte: delay settings
`define FCM_CFG1_FAST_DOUBLE_BIT   7
`define FCM_CFG1_SPIN_DOWN_MSB     6
`define FCM_CFG1_SPIN_DOWN_LSB     4
`define FCM_CFG1_SPIN_UP_MSB       3
`define FCM_CFG1_SPIN_UP_LSB       0

// second configuration byte: feature enables and threshold
`define FCM_CFG2_IMPLIED_SEEK_BIT  6
`define FCM_CFG2_QUEUE_BYPASS_BIT  5
`define FCM_CFG2_POLL_DISABLE_BIT  4
`define FCM_CFG2_THRESHOLD_MSB     3
`define FCM_CFG2_THRESHOLD_LSB     0

// motor on/off command byte
`define FCM_MCMD_ON_OFF_BIT        7
`define FCM_MCMD_DRIVE_MSB         6
`define FCM_MCMD_DRIVE_LSB         5

// reset values
`define FCM_RST_IMPLIED_SEEK       1'h0
`define FCM_RST_QUEUE_BYPASS       1'h1
`define FCM_RST_POLL_DISABLE       1'h0
`define FCM_RST_THRESHOLD_BYTES    5'h01
`define FCM_RST_PRECOMP_TRACK      8'h00
`define FCM_RST_FAST_DOUBLE        1'h0
`define FCM_RST_SPIN_DOWN          3'h6
`define FCM_RST_SPIN_UP            4'h0

// index counts
`define FCM_SPIN_DOWN_BASE         6'h02

// timing
`define FCM_CLK_PERIOD_NS          10
`define FCM_POLL_DWELL_NS          2000

`endif

// ===== rtl/fcm_top.v
// Operation
// - implied seek set: request a seek before read or write; resets off
// - queue bypass set: byte-at-a-time transfers; resets to 1
// - idle and polling enabled: select drives in turn, flag ready changes
// - no polling while head loaded and unload delay not expired
// - queue threshold is field plus one byte; resets to one byte
// - precompensation start track is 8-bit direct; resets to track 0
// - fast disk bit doubles both motor index counts; resets off
// - spin-down waits 2 + 4 x field index pulses before motor off
// - every command completion restarts the spin-down count, except with all delay fields zero
// - spin-down never turns motor off while any drive is busy
// - spin-down field resets to code 110, 26 revolutions
// - all delay fields zero: motor only turned off by motor command
// - spin-up waits spin-up field index pulses before execution
// - motor already on for the drive: no spin-up delay
// - both delays may be short by one revolution, never longer
// - drive selects follow motor one cycle later; delay when unselected or off
// - motor command bit 7 sets motor at once, with two-bit drive
// - drive change skips spin-down wait, only spin-up applies
// - any field combination accepted without checks or errors
`timescale 1ns/1ps
`include "fcm_regs.vh"
module fcm_top #(
  parameter POLL_W = 8
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // configure command parameters
  input  wire       cfg_load,
  input  wire [7:0] cfg_delay_byte,
  input  wire [7:0] cfg_feature_byte,
  input  wire [7:0] cfg_track_byte,
  // motor on/off command
  input  wire       motor_cmd,
  input  wire [7:0] motor_cmd_byte,
  // command sequencing
  input  wire       cmd_start,
  input  wire [1:0] cmd_drive,
  input  wire       cmd_rw,
  input  wire       cmd_done,
  input  wire [3:0] drive_busy,
  input  wire       ctrl_idle,
  input  wire       head_loaded,
  input  wire       head_unload_expired,
  // drive lines
  input  wire       index_in,
  input  wire       drive_ready,
  output reg        motor_out_q,
  output reg        drive_select_bit0_q,
  output reg        drive_select_bit1_q,
  // command results
  output reg        exec_ready_q,
  output reg        seek_request_q,
  output reg        ready_change_q,
  output reg  [1:0] ready_change_drive_q,
  output reg        ready_change_level_q,
  // settings seen by the rest of the controller
  output reg        implied_seek_enable_q,
  output reg        queue_bypass_q,
  output reg        poll_disable_q,
  output reg  [4:0] queue_threshold_q,
  output reg  [7:0] precomp_start_track_q,
  output reg        fast_disk_delay_double_q,
  output reg  [2:0] spin_down_count_q,
  output reg  [3:0] spin_up_count_q
);

  localparam integer POLL_CYC =
    (`FCM_POLL_DWELL_NS + `FCM_CLK_PERIOD_NS - 1) / `FCM_CLK_PERIOD_NS;
  localparam integer POLL_LAST_I = POLL_CYC - 1;
  // cut on purpose: the dwell count must fit the counter width
  localparam [POLL_W-1:0] POLL_LAST = POLL_LAST_I[POLL_W-1:0];

  localparam PS_IDLE  = 1'b0;
  localparam PS_DWELL = 1'b1;

  reg              index_prev_q;
  reg        [1:0] cur_drive_q;
  reg              spin_wait_q;
  reg              poll_state_q;
  reg [POLL_W-1:0] dwell_cnt_q;
  reg        [1:0] poll_drive_q;
  reg        [3:0] ready_seen_q;

  wire       index_tick;
  wire [5:0] sd_rev;
  wire [5:0] sd_value;
  wire [5:0] su_value;
  wire       never_off;
  wire       same_drive_on;
  wire       up_load;
  wire       up_stop;
  wire       dn_load;
  wire       dn_stop;
  wire       up_running;
  wire       up_expire;
  wire       dn_running;
  wire       dn_expire;
  wire       any_busy;
  wire       poll_allow;

  // configure command: every combination stored, threshold as field plus one
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      implied_seek_enable_q    <= `FCM_RST_IMPLIED_SEEK;
      queue_bypass_q           <= `FCM_RST_QUEUE_BYPASS;
      poll_disable_q           <= `FCM_RST_POLL_DISABLE;
      queue_threshold_q        <= `FCM_RST_THRESHOLD_BYTES;
      precomp_start_track_q    <= `FCM_RST_PRECOMP_TRACK;
      fast_disk_delay_double_q <= `FCM_RST_FAST_DOUBLE;
      spin_down_count_q        <= `FCM_RST_SPIN_DOWN;
      spin_up_count_q          <= `FCM_RST_SPIN_UP;
    end else if (cfg_load) begin
      fast_disk_delay_double_q <= cfg_delay_byte[`FCM_CFG1_FAST_DOUBLE_BIT];
      spin_down_count_q        <=
        cfg_delay_byte[`FCM_CFG1_SPIN_DOWN_MSB:`FCM_CFG1_SPIN_DOWN_LSB];
      spin_up_count_q          <=
        cfg_delay_byte[`FCM_CFG1_SPIN_UP_MSB:`FCM_CFG1_SPIN_UP_LSB];
      implied_seek_enable_q    <= cfg_feature_byte[`FCM_CFG2_IMPLIED_SEEK_BIT];
      queue_bypass_q           <= cfg_feature_byte[`FCM_CFG2_QUEUE_BYPASS_BIT];
      poll_disable_q           <= cfg_feature_byte[`FCM_CFG2_POLL_DISABLE_BIT];
      queue_threshold_q        <= {1'b0,
        cfg_feature_byte[`FCM_CFG2_THRESHOLD_MSB:`FCM_CFG2_THRESHOLD_LSB]} + 5'h01;
      precomp_start_track_q    <= cfg_track_byte;
    end
  end

  // index is taken as synchronous; only rising edges count
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      index_prev_q <= 1'b0;
    end else begin
      index_prev_q <= index_in;
    end
  end

  assign index_tick = index_in & ~index_prev_q;

  // index counts; fast disk doubles both
  assign sd_rev   = `FCM_SPIN_DOWN_BASE + {1'b0, spin_down_count_q, 2'b00};
  assign sd_value = fast_disk_delay_double_q ? {sd_rev[4:0], 1'b0} : sd_rev;
  assign su_value = fast_disk_delay_double_q ? {1'b0, spin_up_count_q, 1'b0}
                                             : {2'b00, spin_up_count_q};

  assign never_off = (spin_down_count_q == 3'h0) && (spin_up_count_q == 4'h0) &&
                     !fast_disk_delay_double_q;

  assign same_drive_on = motor_out_q && (cmd_drive == cur_drive_q);
  assign any_busy      = |drive_busy;

  // a new command always cancels a pending spin-down
  assign dn_stop = motor_cmd | cmd_start;
  assign dn_load = ~never_off & (cmd_done | (dn_expire & any_busy));
  assign up_stop = motor_cmd;
  assign up_load = cmd_start & ~same_drive_on & (su_value != 6'h00);

  fcm_index_timer #(
    .W (6)
  ) u_spin_down (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .load       (dn_load),
    .stop       (dn_stop),
    .tick       (index_tick),
    .load_value (sd_value),
    .running_q  (dn_running),
    .expire_q   (dn_expire)
  );

  fcm_index_timer #(
    .W (6)
  ) u_spin_up (
    .sys_clk    (sys_clk),
    .rst_n      (rst_n),
    .load       (up_load),
    .stop       (up_stop),
    .tick       (index_tick),
    .load_value (su_value),
    .running_q  (up_running),
    .expire_q   (up_expire)
  );

  // motor and command release
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      motor_out_q    <= 1'b0;
      cur_drive_q    <= 2'h0;
      spin_wait_q    <= 1'b0;
      exec_ready_q   <= 1'b0;
      seek_request_q <= 1'b0;
    end else begin
      exec_ready_q   <= 1'b0;
      seek_request_q <= 1'b0;
      if (motor_cmd) begin
        // overrides all timers, no delay taken
        motor_out_q <= motor_cmd_byte[`FCM_MCMD_ON_OFF_BIT];
        cur_drive_q <= motor_cmd_byte[`FCM_MCMD_DRIVE_MSB:`FCM_MCMD_DRIVE_LSB];
        spin_wait_q <= 1'b0;
      end else if (cmd_start) begin
        seek_request_q <= cmd_rw & implied_seek_enable_q;
        if (same_drive_on) begin
          exec_ready_q <= 1'b1;
        end else begin
          // motor goes up here; the selects follow cur_drive_q one cycle later, one cycle after exec_ready_q when su_value is zero
          motor_out_q <= 1'b1;
          cur_drive_q <= cmd_drive;
          if (su_value == 6'h00) begin
            exec_ready_q <= 1'b1;
          end else begin
            spin_wait_q <= 1'b1;
          end
        end
      end else begin
        if (spin_wait_q && up_expire) begin
          exec_ready_q <= 1'b1;
          spin_wait_q  <= 1'b0;
        end
        // expiry while busy reloads the count instead
        if (dn_expire && !any_busy) begin
          motor_out_q <= 1'b0;
        end
      end
    end
  end

  // polling only while idle with heads unloaded or the unload delay expired
  assign poll_allow = ~poll_disable_q & ctrl_idle & ~spin_wait_q &
                      ~(head_loaded & ~head_unload_expired);

  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      poll_state_q         <= PS_IDLE;
      dwell_cnt_q          <= {POLL_W{1'b0}};
      poll_drive_q         <= 2'h0;
      ready_seen_q         <= 4'h0;
      ready_change_q       <= 1'b0;
      ready_change_drive_q <= 2'h0;
      ready_change_level_q <= 1'b0;
    end else begin
      ready_change_q <= 1'b0;
      case (poll_state_q)
        PS_IDLE: begin
          dwell_cnt_q <= {POLL_W{1'b0}};
          if (poll_allow) begin
            poll_state_q <= PS_DWELL;
          end
        end
        PS_DWELL: begin
          if (!poll_allow) begin
            poll_state_q <= PS_IDLE;
          end else if (dwell_cnt_q == POLL_LAST) begin
            // sampled at the end so the select has settled
            dwell_cnt_q  <= {POLL_W{1'b0}};
            poll_drive_q <= poll_drive_q + 2'h1;
            if (drive_ready != ready_seen_q[poll_drive_q]) begin
              ready_seen_q[poll_drive_q] <= drive_ready;
              ready_change_q             <= 1'b1;
              ready_change_drive_q       <= poll_drive_q;
              ready_change_level_q       <= drive_ready;
            end
          end else begin
            dwell_cnt_q <= dwell_cnt_q + {{(POLL_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          poll_state_q <= PS_IDLE;
        end
      endcase
    end
  end

  // polling selects stray drives; outside gating must assume it off
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      drive_select_bit0_q <= 1'b0;
      drive_select_bit1_q <= 1'b0;
    end else if (poll_state_q == PS_DWELL) begin
      drive_select_bit0_q <= poll_drive_q[0];
      drive_select_bit1_q <= poll_drive_q[1];
    end else begin
      drive_select_bit0_q <= cur_drive_q[0];
      drive_select_bit1_q <= cur_drive_q[1];
    end
  end

endmodule

// ===== testbench/fcm_drive_model.sv
`timescale 1ns/1ps
module fcm_drive_model #(
  parameter PER = 40
) (
  // clock and reset
  input  wire       sys_clk,
  input  wire       rst_n,
  // controller side
  input  wire       motor,
  input  wire [1:0] sel,
  input  wire [3:0] ready_mask,
  // drive lines
  output reg        index_in,
  output wire       drive_ready
);
  integer ph;
  // a stopped spindle gives no index pulses; selects gate the motor outside
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph <= 0;
      index_in <= 1'b0;
    end else begin
      ph <= (motor && ph < PER - 1) ? ph + 1 : 0;
      index_in <= motor && ph < 4;
    end
  end
  assign drive_ready = ready_mask[sel];
endmodule

// ===== testbench/fcm_top_checker.sv
`timescale 1ns/1ps
module fcm_top_checker (
  // clock and reset
  input wire       sys_clk,
  input wire       rst_n,
  // requests
  input wire       cfg_load,
  input wire [7:0] cfg_feature_byte,
  input wire       motor_cmd,
  input wire [7:0] motor_cmd_byte,
  input wire       cmd_start,
  input wire [1:0] cmd_drive,
  input wire       cmd_rw,
  input wire [3:0] drive_busy,
  input wire       head_loaded,
  input wire       head_unload_expired,
  // results
  input wire       motor_out_q,
  input wire       drive_select_bit0_q,
  input wire       drive_select_bit1_q,
  input wire       exec_ready_q,
  input wire       seek_request_q,
  input wire       ready_change_q,
  // settings
  input wire       implied_seek_enable_q,
  input wire       queue_bypass_q,
  input wire       poll_disable_q,
  input wire [4:0] queue_threshold_q,
  input wire       fast_disk_delay_double_q,
  input wire [2:0] spin_down_count_q,
  input wire [3:0] spin_up_count_q
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!rst_n);
  property p_rst;
    $rose(rst_n) |-> queue_bypass_q && !implied_seek_enable_q && !poll_disable_q &&
      queue_threshold_q == 5'h01 && spin_down_count_q == 3'h6 && spin_up_count_q == 4'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("settings off reset values");
  property p_thr;
    cfg_load |=> queue_threshold_q == {1'b0, $past(cfg_feature_byte[3:0])} + 5'h01;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not field plus one");
  property p_seek;
    cmd_start && !motor_cmd |=> seek_request_q == $past(cmd_rw && implied_seek_enable_q);
  endproperty
  a_seek: assert property (p_seek) else $error("seek request wrong");
  property p_mcmd;
    motor_cmd |=> motor_out_q == $past(motor_cmd_byte[7]);
  endproperty
  a_mcmd: assert property (p_mcmd) else $error("motor command not obeyed");
  property p_msel;
    motor_cmd && poll_disable_q ##1 !motor_cmd && !cmd_start |=>
      {drive_select_bit1_q, drive_select_bit0_q} == $past(motor_cmd_byte[6:5], 2);
  endproperty
  a_msel: assert property (p_msel) else $error("selects miss motor drive");
  property p_busy;
    $fell(motor_out_q) |-> $past(motor_cmd) || $past(drive_busy) == 4'h0;
  endproperty
  a_busy: assert property (p_busy) else $error("motor off while busy");
  property p_inf;
    $fell(motor_out_q) && spin_down_count_q == 3'h0 && spin_up_count_q == 4'h0 &&
      !fast_disk_delay_double_q |-> $past(motor_cmd);
  endproperty
  a_inf: assert property (p_inf) else $error("motor timed off with zero fields");
  property p_hot;
    cmd_start && !motor_cmd && motor_out_q && poll_disable_q &&
      cmd_drive == {drive_select_bit1_q, drive_select_bit0_q} |=> exec_ready_q;
  endproperty
  a_hot: assert property (p_hot) else $error("spin-up delay with motor on");
  property p_nopoll;
    poll_disable_q [*4] |-> !ready_change_q;
  endproperty
  a_nopoll: assert property (p_nopoll) else $error("ready change while poll off");
  property p_hold;
    (head_loaded && !head_unload_expired) [*4] |-> !ready_change_q;
  endproperty
  a_hold: assert property (p_hold) else $error("polling with head loaded");
endmodule
bind fcm_top fcm_top_checker chk_u (.sys_clk, .rst_n, .cfg_load, .cfg_feature_byte,
  .motor_cmd, .motor_cmd_byte, .cmd_start, .cmd_drive, .cmd_rw, .drive_busy, .head_loaded,
  .head_unload_expired, .motor_out_q, .drive_select_bit0_q, .drive_select_bit1_q,
  .exec_ready_q, .seek_request_q, .ready_change_q, .implied_seek_enable_q, .queue_bypass_q,
  .poll_disable_q, .queue_threshold_q, .fast_disk_delay_double_q, .spin_down_count_q,
  .spin_up_count_q);

// ===== testbench/testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED %0t line %0d", $time, `__LINE__); end end
module testbench;
  reg        sys_clk, rst_n, cfg_load, motor_cmd, cmd_start, cmd_rw, cmd_done;
  reg        ctrl_idle, head_loaded, head_unload_expired;
  reg  [7:0] cfg_delay_byte, cfg_feature_byte, cfg_track_byte, motor_cmd_byte;
  reg  [1:0] cmd_drive;
  reg  [3:0] drive_busy, ready_mask;
  wire       index_in, drive_ready, motor_out_q, drive_select_bit0_q, drive_select_bit1_q;
  wire       exec_ready_q, seek_request_q, ready_change_q, ready_change_level_q;
  wire       implied_seek_enable_q, queue_bypass_q, poll_disable_q, fast_disk_delay_double_q;
  wire [1:0] ready_change_drive_q;
  wire [4:0] queue_threshold_q;
  wire [7:0] precomp_start_track_q;
  wire [2:0] spin_down_count_q;
  wire [3:0] spin_up_count_q;
  int        bad_count, n_tests, c;
  bit        h;
  fcm_top dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .cfg_load(cfg_load),
    .cfg_delay_byte(cfg_delay_byte), .cfg_feature_byte(cfg_feature_byte),
    .cfg_track_byte(cfg_track_byte), .motor_cmd(motor_cmd), .motor_cmd_byte(motor_cmd_byte),
    .cmd_start(cmd_start), .cmd_drive(cmd_drive), .cmd_rw(cmd_rw), .cmd_done(cmd_done),
    .drive_busy(drive_busy), .ctrl_idle(ctrl_idle), .head_loaded(head_loaded),
    .head_unload_expired(head_unload_expired), .index_in(index_in),
    .drive_ready(drive_ready), .motor_out_q(motor_out_q),
    .drive_select_bit0_q(drive_select_bit0_q), .drive_select_bit1_q(drive_select_bit1_q),
    .exec_ready_q(exec_ready_q), .seek_request_q(seek_request_q),
    .ready_change_q(ready_change_q), .ready_change_drive_q(ready_change_drive_q),
    .ready_change_level_q(ready_change_level_q),
    .implied_seek_enable_q(implied_seek_enable_q), .queue_bypass_q(queue_bypass_q),
    .poll_disable_q(poll_disable_q), .queue_threshold_q(queue_threshold_q),
    .precomp_start_track_q(precomp_start_track_q),
    .fast_disk_delay_double_q(fast_disk_delay_double_q),
    .spin_down_count_q(spin_down_count_q), .spin_up_count_q(spin_up_count_q));
  fcm_drive_model drv_u (.sys_clk(sys_clk), .rst_n(rst_n), .motor(motor_out_q),
    .sel({drive_select_bit1_q, drive_select_bit0_q}), .ready_mask(ready_mask),
    .index_in(index_in), .drive_ready(drive_ready));
  task final_report;
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // configure command: three parameter bytes in one load cycle
  task cfg(input [7:0] d, input [7:0] f, input [7:0] t);
    @(posedge sys_clk);
    cfg_load <= 1'b1;
    {cfg_delay_byte, cfg_feature_byte, cfg_track_byte} <= {d, f, t};
    @(posedge sys_clk);
    cfg_load <= 1'b0;
    @(negedge sys_clk);
  endtask
  // k: 0 motor command, 1 command start, 2 command done
  task go(input [1:0] k, input [7:0] b);
    @(posedge sys_clk);
    {motor_cmd, cmd_start, cmd_done} <= {k == 2'd0, k == 2'd1, k == 2'd2};
    motor_cmd_byte <= b;
    cmd_drive <= b[6:5];
    @(posedge sys_clk);
    {motor_cmd, cmd_start, cmd_done} <= 3'b000;
  endtask
  // index rises until exec pulse or motor off; -9 when it never comes
  task cnt(input bit ex, output int n);
    reg p;
    int i;
    n = 0;
    p = index_in;
    for (i = 0; i < 5000; i++) begin
      @(negedge sys_clk);
      if (index_in && !p)
        n++;
      p = index_in;
      if (ex ? exec_ready_q === 1'b1 : motor_out_q === 1'b0)
        break;
    end
    if (i == 5000)
      n = -9;
  endtask
  task wait_rc(input int lim, output bit hit);
    int i;
    hit = 0;
    for (i = 0; i < lim && !hit; i++) begin
      @(negedge sys_clk);
      hit = ready_change_q;
    end
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    #500000;
    bad_count++;
    final_report;
  end
  initial begin
    {rst_n, cfg_load, motor_cmd, cmd_start, cmd_done, head_loaded} = 6'h00;
    {ctrl_idle, cmd_rw, head_unload_expired} = 3'b110;
    {cfg_delay_byte, cfg_feature_byte, cfg_track_byte, motor_cmd_byte} = 32'h0;
    {cmd_drive, drive_busy, ready_mask} = 10'h004;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(negedge sys_clk);
    `CHK(implied_seek_enable_q, 1'b0)
    `CHK(queue_bypass_q, 1'b1)
    `CHK(poll_disable_q, 1'b0)
    `CHK(queue_threshold_q, 5'h01)
    `CHK(precomp_start_track_q, 8'h00)
    `CHK(fast_disk_delay_double_q, 1'b0)
    `CHK(spin_down_count_q, 3'h6)
    `CHK(spin_up_count_q, 4'h0)
    $display("test reset done");
    wait_rc(2000, h);
    `CHK({h, ready_change_drive_q, ready_change_level_q}, 4'b1101)
    @(posedge sys_clk);
    {head_loaded, ready_mask} <= 5'h10;
    wait_rc(1500, h);
    `CHK(h, 1'b0)
    @(posedge sys_clk);
    head_loaded <= 1'b0;
    wait_rc(2000, h);
    `CHK({h, ready_change_drive_q, ready_change_level_q}, 4'b1100)
    $display("test polling done");
    cfg(8'h93, 8'h5f, 8'hff);
    `CHK({implied_seek_enable_q, queue_bypass_q, poll_disable_q}, 3'b101)
    `CHK(queue_threshold_q, 5'h10)
    `CHK(precomp_start_track_q, 8'hff)
    `CHK({fast_disk_delay_double_q, spin_down_count_q, spin_up_count_q}, 8'h93)
    go(0, 8'hc0);
    @(negedge sys_clk);
    `CHK(motor_out_q, 1'b1)
    @(negedge sys_clk);
    `CHK({drive_select_bit1_q, drive_select_bit0_q}, 2'd2)
    go(0, 8'h40);
    @(negedge sys_clk);
    `CHK(motor_out_q, 1'b0)
    $display("test motor command done");
    go(1, 8'h20);
    @(negedge sys_clk);
    `CHK(seek_request_q, 1'b1)
    cnt(1, c);
    `CHK(c >= 5 && c <= 6, 1'b1)
    go(1, 8'h20);
    @(negedge sys_clk);
    `CHK(exec_ready_q, 1'b1)
    go(1, 8'h60);
    cnt(1, c);
    `CHK(c >= 5 && c <= 6, 1'b1)
    $display("test spin-up done");
    @(posedge sys_clk) drive_busy <= 4'h8;
    go(2, 8'h00);
    repeat (1200) @(negedge sys_clk);
    `CHK(motor_out_q, 1'b1)
    @(posedge sys_clk) drive_busy <= 4'h0;
    go(2, 8'h00);
    repeat (240) @(negedge sys_clk);
    go(2, 8'h00);
    cnt(0, c);
    `CHK(c >= 11 && c <= 12, 1'b1)
    $display("test spin-down done");
    cfg(8'h00, 8'h10, 8'h00);
    `CHK(queue_threshold_q, 5'h01)
    go(1, 8'h00);
    @(negedge sys_clk);
    `CHK(exec_ready_q, 1'b1)
    go(2, 8'h00);
    repeat (1600) @(negedge sys_clk);
    `CHK(motor_out_q, 1'b1)
    $display("test zero delays done");
    final_report;
  end
endmodule
